/* exec_defs.vh */
/*
  Constants for the table access and exclusive-OR execution block:
  register offsets, field positions, reset values, opcode patterns and
  phase timing. Assumes inclusion by bare name from each design file.
*/
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

// Register byte offsets on the APB
`define OFS_CTRL 12'h000
`define OFS_INSTR 12'h004
`define OFS_STATUS 12'h008
`define OFS_WORK 12'h00C
`define OFS_BANK 12'h010
`define OFS_TPTR 12'h014
`define OFS_TLAT 12'h018
`define OFS_IBASE 12'h01C
`define OFS_HOLD_LO 12'h020
`define OFS_HOLD_HI 12'h024
`define OFS_FILE_BASE 12'h040
`define OFS_FILE_MASK 12'hFC0

// Control fields
`define CTRL_EXT_BIT 0
`define CTRL_TWO_WORD_BIT 1

// Status fields
`define STAT_BUSY_BIT 0
`define STAT_SKIP_BIT 1
`define STAT_Z_BIT 2
`define STAT_N_BIT 3
`define STAT_CYC_LSB 4
`define STAT_ILLEGAL_BIT 6

// Widths
`define TPTR_W 21
`define FADDR_W 12

// Reset values
`define RST_BYTE 8'h00
`define RST_TPTR 21'h00_0000
`define RST_IBASE 12'h000
`define RST_OPCODE 16'h0000

// Opcode patterns
`define OP_TBL_HI 14'h0002
`define OP_TBL_WR_HI 14'h0003
`define OP_TST_SKIP 7'b0110_011
`define OP_XOR_LIT 8'h0A
`define OP_XOR_FILE 6'b0001_10

// Pointer update modes
`define MODE_KEEP 2'h0
`define MODE_POST_INC 2'h1
`define MODE_POST_DEC 2'h2
`define MODE_PRE_INC 2'h3

// Access bank split and indexed limit
`define ACCESS_SPLIT 8'h60
`define INDEXED_LIMIT 8'h5F
`define SFR_PAGE 4'hF

// Phases per instruction cycle
`define PHASES 3'h4

`endif

/* pm_model.sv */
/*
  Program memory stand-in for the table read path.
  Assumes pm_rd is a one-cycle pulse with pm_addr already stable.
*/
`timescale 1ns/100ps

module pm_model (
  input wire clock,
  input wire [20:0] pm_addr,
  input wire pm_rd,
  output wire [7:0] pm_rdata
);
  reg [7:0] held;
  reg [7:0] junk;
  reg [1:0] hold_cnt;

  // Contents depend on every address bit, so a wrong bit shows
  function [7:0] pm_byte(input [20:0] a);
    pm_byte = a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
  endfunction

  initial begin
    held = 8'h00;
    junk = 8'h5A;
    hold_cnt = 2'h0;
  end

  // Data kept for two cycles after the strobe, one cycle past the end of the instruction cycle
  always @(posedge clock) begin
    junk <= ~junk;
    if (pm_rd) begin
      held <= pm_byte(pm_addr);
      hold_cnt <= 2'h2;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end
  end

  // Outside the hold window the line toggles, never stale
  assign pm_rdata = pm_rd ? pm_byte(pm_addr) :
                    (hold_cnt != 2'h0) ? held : junk;
endmodule

/* q_phase_gen.v */
/*
  Four-phase sequencer: splits each instruction cycle into one-hot
  phase enables. Assumes one clock, synchronous reset, and that run
  stays high for whole instruction cycles.
*/
`timescale 1ns/100ps
`include "exec_defs.vh"

module q_phase_gen (
  input wire clock,
  input wire srst,
  input wire run,
  output wire [3:0] q
);

  reg [1:0] phase_reg;
  reg [1:0] phase_next;

  // Next phase, parked at Q1 while idle
  always @* begin
    if (!run) begin
      phase_next = 2'h0;
    end else begin
      phase_next = phase_reg + 2'h1;
    end
  end

  // Phase counter
  always @(posedge clock) begin
    if (srst) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // One-hot enables, only while running
  assign q = run ? (4'h1 << phase_reg) : 4'h0;

endmodule

/* table_xor_exec.v */
/*
  Execution core for table read/write, test-and-skip-if-zero and the two
  exclusive-OR instructions, with an APB register slave. Software issues
  one opcode at a time through the instruction register. Assumes the
  program memory returns pm_rdata for pm_addr while pm_rd is high and
  holds it until the end of the instruction cycle.
*/
// Behaviour
// RULE1: A table read loads the addressed program byte into the table latch over two cycles and leaves flags alone.
// RULE2: The table pointer is a 21-bit byte address covering two megabytes.
// RULE3: Pointer bit 0 picks the low byte when zero and the high byte when one.
// RULE4: Table read mode 0 keeps the pointer, 1 post-increments, 2 post-decrements, 3 pre-increments.
// RULE5: A table write copies the latch into one of eight holding registers picked by pointer bits 2..0.
// RULE6: A table write uses the same four pointer modes, keeps flags and takes two cycles.
// RULE7: The holding registers are the data source for later programming of program memory.
// RULE8: Test-and-skip replaces the next instruction with a no-operation when the file register is zero.
// RULE9: A taken skip over a two-word instruction makes three cycles in all, extra ones idle.
// RULE10: Access bit zero selects the access bank, one selects the bank given by the bank select register.
// RULE11: With the extended set on and access bit zero, file addresses up to 95 are indexed offsets.
// RULE12: Literal exclusive-OR writes W xor literal to W and updates N and Z in one cycle.
// RULE13: Register exclusive-OR writes W xor f to W when d is zero or to f when d is one and updates N and Z.
// RULE14: Table write samples the latch early and writes the holding register in the last phase; table read writes the latch in the last phase.
`timescale 1ns/100ps
`include "exec_defs.vh"

module table_xor_exec (
  input wire clock,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg [20:0] pm_addr,
  output reg pm_rd,
  input wire [7:0] pm_rdata,
  output wire [63:0] hold_data,
  output wire busy
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_C1 = 4'b0010;
  localparam ST_C2 = 4'b0100;
  localparam ST_C3 = 4'b1000;

  reg [3:0] state_reg;
  reg [15:0] opcode_reg;
  reg [1:0] ctrl_reg;
  reg [7:0] work_reg;
  reg [3:0] bank_select_reg;
  reg [20:0] table_pointer;
  reg [7:0] table_latch;
  reg [11:0] ibase_reg;
  reg [7:0] file_mem [0:15];
  reg [7:0] hold_mem [0:7];
  reg [7:0] opnd_reg;
  reg [7:0] wt_sample_reg;
  reg skip_reg;
  reg flag_z_reg;
  reg flag_n_reg;
  reg illegal_reg;
  reg [1:0] cycles_reg;
  reg [31:0] rdata_next;
  reg [63:0] hold_flat;
  integer i;
  integer j;

  wire [3:0] q;
  wire apb_wr;
  wire apb_rd;
  wire idle;
  wire is_table_read;
  wire is_table_write;
  wire is_tst;
  wire is_xor_lit;
  wire is_xor_file;
  wire [1:0] mode;
  wire [11:0] faddr;
  wire [3:0] fidx;
  wire [7:0] xor_res;
  wire file_hit;
  wire [3:0] file_sel;

  // Pointer step for the four update modes, shared by read and write
  function [20:0] ptr_step;
    input [20:0] ptr;
    input [1:0] md;
    input pre;
    begin
      ptr_step = ptr;
      if (pre && md == `MODE_PRE_INC) begin
        ptr_step = ptr + 21'h00_0001;
      end else if (!pre && md == `MODE_POST_INC) begin
        ptr_step = ptr + 21'h00_0001;
      end else if (!pre && md == `MODE_POST_DEC) begin
        ptr_step = ptr - 21'h00_0001;
      end
    end
  endfunction

  // Effective file address from f, access bit, bank and extended mode
  function [11:0] file_addr;
    input [7:0] f;
    input acc;
    input [3:0] bank;
    input ext;
    input [11:0] base;
    begin
      if (acc) begin
        file_addr = {bank, f}; // RULE10
      end else if (ext && f <= `INDEXED_LIMIT) begin
        file_addr = base + {4'h0, f}; // RULE11
      end else if (f < `ACCESS_SPLIT) begin
        file_addr = {4'h0, f}; // RULE10
      end else begin
        file_addr = {`SFR_PAGE, f};
      end
    end
  endfunction

  q_phase_gen u_phase (
    .clock(clock),
    .srst(srst),
    .run(!idle),
    .q(q)
  );

  // Decode of the held opcode
  // Bits 3..2 tell read (10) from write (11); bits 1..0 are the mode
  assign is_table_read = opcode_reg[15:2] == `OP_TBL_HI; // RULE4
  assign is_table_write = opcode_reg[15:2] == `OP_TBL_WR_HI; // RULE6
  assign is_tst = opcode_reg[15:9] == `OP_TST_SKIP; // RULE8
  assign is_xor_lit = opcode_reg[15:8] == `OP_XOR_LIT; // RULE12
  assign is_xor_file = opcode_reg[15:10] == `OP_XOR_FILE; // RULE13
  assign mode = opcode_reg[1:0];
  assign faddr = file_addr(opcode_reg[7:0], opcode_reg[8], bank_select_reg,
    ctrl_reg[`CTRL_EXT_BIT], ibase_reg);
  // Only sixteen file bytes are built; upper address bits alias
  assign fidx = faddr[3:0];
  assign xor_res = work_reg ^ (is_xor_lit ? opcode_reg[7:0] : opnd_reg);

  // APB handshake: zero wait states
  assign idle = state_reg == ST_IDLE;
  assign busy = !idle;
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign file_hit = (paddr & `OFS_FILE_MASK) == `OFS_FILE_BASE;
  assign file_sel = paddr[5:2];
  assign pslverr = psel && penable && !file_hit && !(
    paddr == `OFS_CTRL || paddr == `OFS_INSTR || paddr == `OFS_STATUS ||
    paddr == `OFS_WORK || paddr == `OFS_BANK || paddr == `OFS_TPTR ||
    paddr == `OFS_TLAT || paddr == `OFS_IBASE ||
    paddr == `OFS_HOLD_LO || paddr == `OFS_HOLD_HI);

  // Holding registers packed for the programming logic
  always @* begin
    hold_flat = 64'h0000_0000_0000_0000;
    for (j = 0; j < 8; j = j + 1) begin
      hold_flat[j*8 +: 8] = hold_mem[j];
    end
  end
  assign hold_data = hold_flat; // RULE7

  // Read data mux
  always @* begin
    rdata_next = 32'h0000_0000;
    if (file_hit) begin
      rdata_next[7:0] = file_mem[file_sel];
    end else begin
      case (paddr)
        `OFS_CTRL: rdata_next[1:0] = ctrl_reg;
        `OFS_INSTR: rdata_next[15:0] = opcode_reg;
        `OFS_STATUS: begin
          rdata_next[`STAT_BUSY_BIT] = busy;
          rdata_next[`STAT_SKIP_BIT] = skip_reg;
          rdata_next[`STAT_Z_BIT] = flag_z_reg;
          rdata_next[`STAT_N_BIT] = flag_n_reg;
          rdata_next[`STAT_CYC_LSB +: 2] = cycles_reg;
          rdata_next[`STAT_ILLEGAL_BIT] = illegal_reg;
        end
        `OFS_WORK: rdata_next[7:0] = work_reg;
        `OFS_BANK: rdata_next[3:0] = bank_select_reg;
        `OFS_TPTR: rdata_next[20:0] = table_pointer; // RULE2
        `OFS_TLAT: rdata_next[7:0] = table_latch;
        `OFS_IBASE: rdata_next[11:0] = ibase_reg;
        `OFS_HOLD_LO: rdata_next = hold_flat[31:0];
        `OFS_HOLD_HI: rdata_next = hold_flat[63:32];
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end
  assign prdata = apb_rd ? rdata_next : 32'h0000_0000;

  // Sequencer, execution and software writes; while busy, software writes
  // are ignored except to the control register, which can change mid-instruction
  always @(posedge clock) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      opcode_reg <= `RST_OPCODE;
      ctrl_reg <= 2'h0;
      work_reg <= `RST_BYTE;
      bank_select_reg <= 4'h0;
      table_pointer <= `RST_TPTR;
      table_latch <= `RST_BYTE;
      ibase_reg <= `RST_IBASE;
      opnd_reg <= `RST_BYTE;
      wt_sample_reg <= `RST_BYTE;
      skip_reg <= 1'b0;
      flag_z_reg <= 1'b0;
      flag_n_reg <= 1'b0;
      illegal_reg <= 1'b0;
      cycles_reg <= 2'h0;
      pm_addr <= `RST_TPTR;
      pm_rd <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        file_mem[i] <= `RST_BYTE;
      end
      for (i = 0; i < 8; i = i + 1) begin
        hold_mem[i] <= `RST_BYTE;
      end
    end else begin
      pm_rd <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (apb_wr && !file_hit) begin
            case (paddr)
              `OFS_CTRL: ctrl_reg <= pwdata[1:0];
              `OFS_INSTR: begin
                // Issue: start the first instruction cycle
                opcode_reg <= pwdata[15:0];
                skip_reg <= 1'b0;
                illegal_reg <= 1'b0;
                state_reg <= ST_C1;
              end
              `OFS_WORK: work_reg <= pwdata[7:0];
              `OFS_BANK: bank_select_reg <= pwdata[3:0];
              `OFS_TPTR: table_pointer <= pwdata[20:0];
              `OFS_TLAT: table_latch <= pwdata[7:0];
              `OFS_IBASE: ibase_reg <= pwdata[11:0];
              default: ;
            endcase
          end else if (apb_wr) begin
            file_mem[file_sel] <= pwdata[7:0];
          end
        end
        ST_C1: begin
          if (apb_wr && paddr == `OFS_CTRL) begin
            ctrl_reg <= pwdata[1:0];
          end
          // Q2: operand read
          if (q[1]) begin
            opnd_reg <= file_mem[fidx];
          end
          // Q3: zero test decides the skip
          if (q[2] && is_tst) begin
            skip_reg <= opnd_reg == `RST_BYTE; // RULE8
          end
          if (q[3]) begin
            if (is_xor_lit || is_xor_file) begin
              flag_z_reg <= xor_res == `RST_BYTE; // RULE12 RULE13
              flag_n_reg <= xor_res[7];
              if (is_xor_file && opcode_reg[9]) begin
                file_mem[fidx] <= xor_res; // RULE13
              end else begin
                work_reg <= xor_res; // RULE12
              end
            end
            if (is_table_read || is_table_write) begin
              table_pointer <= ptr_step(table_pointer, mode, 1'b1); // RULE4
            end
            illegal_reg <= !(is_table_read || is_table_write || is_tst ||
              is_xor_lit || is_xor_file);
            if (is_table_read || is_table_write || (is_tst && skip_reg)) begin
              cycles_reg <= 2'h2;
              state_reg <= ST_C2; // RULE1 RULE6
            end else begin
              cycles_reg <= 2'h1;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_C2: begin
          if (apb_wr && paddr == `OFS_CTRL) begin
            ctrl_reg <= pwdata[1:0];
          end
          // Q1: present the byte address to program memory
          if (q[0] && is_table_read) begin
            pm_addr <= table_pointer; // RULE3
          end
          if (q[1] && is_table_read) begin
            pm_rd <= 1'b1;
          end
          // Q2: latch sampled early for a table write
          if (q[1] && is_table_write) begin
            wt_sample_reg <= table_latch; // RULE14
          end
          if (q[3]) begin
            if (is_table_read) begin
              table_latch <= pm_rdata; // RULE1 RULE14
            end
            if (is_table_write) begin
              hold_mem[table_pointer[2:0]] <= wt_sample_reg; // RULE5 RULE14
            end
            if (is_table_read || is_table_write) begin
              table_pointer <= ptr_step(table_pointer, mode, 1'b0); // RULE4 RULE6
            end
            if (is_tst && ctrl_reg[`CTRL_TWO_WORD_BIT]) begin
              cycles_reg <= 2'h3;
              state_reg <= ST_C3; // RULE9
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_C3: begin
          if (apb_wr && paddr == `OFS_CTRL) begin
            ctrl_reg <= pwdata[1:0];
          end
          // Second idle cycle for the skipped second word
          if (q[3]) begin
            state_reg <= ST_IDLE; // RULE9
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

/* table_xor_exec_monitor.sv */
/*
  Port checker for the execution block, bound to its top module.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/100ps

module table_xor_exec_monitor (
  input wire clock,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [20:0] pm_addr,
  input wire pm_rd,
  input wire [7:0] pm_rdata,
  input wire [63:0] hold_data,
  input wire busy
);
  reg [63:0] hold_q;
  wire [7:0] byte_chg;
  genvar i;

  // Previous holding bytes, cleared with the design
  always @(posedge clock) begin
    if (srst)
      hold_q <= 64'h0000_0000_0000_0000;
    else
      hold_q <= hold_data;
  end

  // One flag per holding byte that changed
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_chg
      assign byte_chg[i] = |(hold_data[8*i+7:8*i] ^ hold_q[8*i+7:8*i]);
    end
  endgenerate

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_read_tail;
    busy [*2] ##1 !busy;
  endsequence
  sequence s_one_cycle;
    busy [*4];
  endsequence

  property p_pm_rd_pulse;
    pm_rd |=> !pm_rd;
  endproperty
  property p_pm_rd_ctx;
    pm_rd |-> busy && $stable(pm_addr);
  endproperty
  property p_read_tail;
    $rose(pm_rd) |-> s_read_tail;
  endproperty
  property p_busy_min;
    $rose(busy) |-> s_one_cycle;
  endproperty
  property p_busy_max;
    $rose(busy) |-> ##[1:12] !busy;
  endproperty
  property p_hold_one;
    $onehot0(byte_chg);
  endproperty
  property p_hold_end;
    (byte_chg != 8'h00) |-> $fell(busy);
  endproperty
  property p_ready;
    psel && penable |-> pready;
  endproperty

  a_pm_rd_pulse: assert property (p_pm_rd_pulse)
    else $error("program read strobe longer than one cycle");
  a_pm_rd_ctx: assert property (p_pm_rd_ctx)
    else $error("program read while idle or address moving");
  a_read_tail: assert property (p_read_tail)
    else $error("table read does not end two cycles in");
  a_busy_min: assert property (p_busy_min)
    else $error("instruction shorter than one cycle");
  a_busy_max: assert property (p_busy_max)
    else $error("instruction longer than three cycles");
  a_hold_one: assert property (p_hold_one)
    else $error("more than one holding byte changed");
  a_hold_end: assert property (p_hold_end)
    else $error("holding byte changed outside the last phase");
  a_ready: assert property (p_ready)
    else $error("access phase without ready");
endmodule

bind table_xor_exec table_xor_exec_monitor mon (.clock(clock), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
  .hold_data(hold_data), .busy(busy));

/* tb.sv */
/*
  Testbench: APB tasks issue opcodes and compare results.
  Assumes the program memory model and the bound checker.
*/
`timescale 1ns/100ps
`include "exec_defs.vh"

module tb;
  reg clock, srst, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd_data;
  wire [31:0] prdata;
  wire pready, pslverr, pm_rd, busy;
  wire [20:0] pm_addr;
  wire [7:0] pm_rdata;
  wire [63:0] hold_data;
  integer failures, check_count, m, n;
  reg rd_err;
  reg [20:0] p;
  reg [63:0] exp_hold;
  reg [20:0] ptr0 [0:3];

  table_xor_exec dut (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
    .hold_data(hold_data), .busy(busy));
  pm_model pm (.clock(clock), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_rdata(pm_rdata));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  function [7:0] exp_byte(input [20:0] a);
    exp_byte = a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
  endfunction
  // Status word: illegal, cycles, N, Z, skip, busy clear
  function [31:0] st(input sk, input z, input ng, input [1:0] cy,
                     input il);
    st = {25'h000_0000, il, cy, ng, z, sk, 1'b0};
  endfunction

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input string what, input [63:0] exp, input [63:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // One APB transfer; request held until ready is sampled
  task apb(input wr, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      @(posedge clock);
      while (pready !== 1'b1 && k < 16) begin
        k = k + 1;
        @(posedge clock);
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 16) begin
        failures = failures + 1;
        report_and_stop;
      end
    end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd_chk(input [11:0] a, input [31:0] exp, input string what);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(what, exp, rd_data);
    end
  endtask
  // Counts busy cycles; a hang ends the run
  task wait_idle;
    begin
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (busy === 1'b1 && n < 40);
      if (n >= 40) begin
        failures = failures + 1;
        report_and_stop;
      end
    end
  endtask
  task run(input [15:0] op, input integer cyc);
    begin
      wr(`OFS_INSTR, {16'h0000, op});
      wait_idle;
      chk("clocks", cyc, n - 1);
    end
  endtask

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    failures = 0;
    check_count = 0;
    exp_hold = 64'h0000_0000_0000_0000;
    ptr0[0] = 21'h00_A356;
    ptr0[1] = 21'h00_A355;
    ptr0[2] = 21'h00_0000;
    ptr0[3] = 21'h01_389A;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    // Reset state and an unmapped hole
    rd_chk(`OFS_STATUS, 32'h0000_0000, "status");
    rd_chk(`OFS_TPTR, 32'h0000_0000, "pointer");
    rd_chk(`OFS_HOLD_LO, 32'h0000_0000, "hold lo");
    rd_chk(12'h030, 32'h0000_0000, "hole");
    chk("slverr", 1, rd_err);
    $display("test reset done");
    // Literal exclusive-OR, flags both ways
    wr(`OFS_WORK, 32'h0000_00B5);
    run(16'h0AAF, 4);
    rd_chk(`OFS_WORK, 32'h0000_001A, "w");
    run(16'h0A1A, 4);
    rd_chk(`OFS_STATUS, st(0, 1, 0, 1, 0), "status");
    run(16'h0A80, 4);
    rd_chk(`OFS_STATUS, st(0, 0, 1, 1, 0), "status");
    $display("test xor literal done");
    // Table read in every mode, with wrap below zero
    for (m = 0; m < 4; m = m + 1) begin
      wr(`OFS_TPTR, {11'h000, ptr0[m]});
      p = ptr0[m] + 21'(m == 3);
      run({`OP_TBL_HI, m[1:0]}, 8);
      rd_chk(`OFS_TLAT, {24'h00_0000, exp_byte(p)}, "latch");
      p = p + 21'(m == 1) - 21'(m == 2);
      rd_chk(`OFS_TPTR, {11'h000, p}, "pointer");
      rd_chk(`OFS_STATUS, st(0, 0, 1, 2, 0), "status");
    end
    // Register write while busy is ignored
    wr(`OFS_INSTR, 32'h0000_0008);
    wr(`OFS_WORK, 32'h0000_0077);
    wait_idle;
    rd_chk(`OFS_WORK, 32'h0000_0080, "w");
    $display("test table read done");
    // Table write in every mode into distinct holding bytes
    for (m = 0; m < 4; m = m + 1) begin
      wr(`OFS_TLAT, {24'h00_0000, 6'h31, m[1:0]});
      wr(`OFS_TPTR, {11'h000, ptr0[m]});
      p = ptr0[m] + 21'(m == 3);
      exp_hold[8 * p[2:0] +: 8] = {6'h31, m[1:0]};
      run({14'h0003, m[1:0]}, 8);
      chk("hold", exp_hold, hold_data);
      p = p + 21'(m == 1) - 21'(m == 2);
      rd_chk(`OFS_TPTR, {11'h000, p}, "pointer");
    end
    rd_chk(`OFS_HOLD_LO, exp_hold[31:0], "hold lo");
    rd_chk(`OFS_HOLD_HI, exp_hold[63:32], "hold hi");
    rd_chk(`OFS_STATUS, st(0, 0, 1, 2, 0), "status");
    $display("test table write done");
    // Register exclusive-OR: destinations and addressing
    wr(`OFS_FILE_BASE + 12'h014, 32'h0000_00AF);
    wr(`OFS_WORK, 32'h0000_00B5);
    run(16'h1A05, 4);
    rd_chk(`OFS_FILE_BASE + 12'h014, 32'h0000_001A, "file");
    run(16'h1805, 4);
    rd_chk(`OFS_WORK, 32'h0000_00AF, "w");
    rd_chk(`OFS_STATUS, st(0, 0, 1, 1, 0), "status");
    wr(`OFS_BANK, 32'h0000_0002);
    wr(`OFS_FILE_BASE + 12'h01C, 32'h0000_000F);
    run(16'h1B07, 4);
    rd_chk(`OFS_FILE_BASE + 12'h01C, 32'h0000_00A0, "file");
    wr(`OFS_CTRL, 32'h0000_0001);
    wr(`OFS_IBASE, 32'h0000_0004);
    run(16'h1A03, 4);
    rd_chk(`OFS_FILE_BASE + 12'h01C, 32'h0000_000F, "file");
    rd_chk(`OFS_STATUS, st(0, 0, 0, 1, 0), "status");
    $display("test xor file done");
    // Test-and-skip: not taken, taken, taken over two words
    wr(`OFS_CTRL, 32'h0000_0000);
    wr(`OFS_FILE_BASE + 12'h00C, 32'h0000_0000);
    run(16'h6605, 4);
    rd_chk(`OFS_STATUS, st(0, 0, 0, 1, 0), "status");
    run(16'h6603, 8);
    rd_chk(`OFS_STATUS, st(1, 0, 0, 2, 0), "status");
    wr(`OFS_CTRL, 32'h0000_0002);
    run(16'h6703, 12);
    rd_chk(`OFS_STATUS, st(1, 0, 0, 3, 0), "status");
    run(16'hFFFF, 4);
    rd_chk(`OFS_STATUS, st(0, 0, 0, 1, 1), "status");
    $display("test skip done");
    report_and_stop;
  end
endmodule
